// [src/irpe_pkg.sv]
// Shared constants and types for the infrared pulse encoder/decoder
package irpe_pkg;

  // ****************************************************************
  // System clock
  // ****************************************************************
  localparam int SYS_CLK_MHZ = 20;

  // ****************************************************************
  // Bit-clock slot timing
  // ****************************************************************
  localparam int                TICK_W          = 4;
  localparam int                SLOT_W          = 4;
  localparam logic [TICK_W-1:0] ENC_SAMPLE_TICK = 4'h7;
  localparam logic [TICK_W-1:0] ENC_HIGH_TICKS  = 4'h3;
  localparam logic [TICK_W-1:0] DEC_DELAY_TICKS = 4'h4;
  localparam logic [TICK_W-1:0] SLOT_LAST_TICK  = 4'hf;
  localparam logic [SLOT_W-1:0] FRAME_LAST_SLOT = 4'h9;

  // ****************************************************************
  // Times in ns and their cycle counts
  // ****************************************************************
  // Longest time rounds down
  localparam int LIMIT_NS      = 4000;
  localparam int LIMIT_CYC     = (LIMIT_NS * SYS_CLK_MHZ) / 1000;
  localparam int LIMIT_W       = $clog2(LIMIT_CYC + 1);
  // Least times round up
  localparam int PULSE_MIN_NS  = 1600;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int PULSE_W       = $clog2(PULSE_MIN_CYC + 1);
  localparam int RST_FILT_NS   = 1000;
  localparam int RST_FILT_CYC  = (RST_FILT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int FILT_W        = $clog2(RST_FILT_CYC + 1);

  // ****************************************************************
  // Reset levels and buffering
  // ****************************************************************
  localparam logic HOST_IDLE  = 1'b1;
  localparam logic IR_IDLE    = 1'b0;
  localparam int   FIFO_WIDTH = 1;
  localparam int   FIFO_DEPTH = 8;

  typedef enum logic [0:0] {ENC_IDLE, ENC_FRAME} irpe_enc_t;
  typedef enum logic [0:0] {DEC_IDLE, DEC_WAIT} irpe_dec_t;

endpackage

// [src/irpe_fifo_if.sv]
// Valid/ready carrier between the encoder front end and its bit FIFO
interface irpe_fifo_if #(parameter int WIDTH = 1);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo_side (input push_valid, push_data, pop_ready,
                     output push_ready, pop_valid, pop_data);
  modport user_side (output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
endinterface

// [src/irpe_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides
module irpe_fifo
  import irpe_pkg::*;
#(
  parameter int WIDTH = irpe_pkg::FIFO_WIDTH,
  parameter int DEPTH = irpe_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Both sides
  irpe_fifo_if.fifo_side  q
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } irpe_fifo_st_t;

  irpe_fifo_st_t st;
  irpe_fifo_st_t next_st;

  // Honest flags straight from the fill count
  assign q.push_ready = (st.cnt != CW'(DEPTH));
  assign q.pop_valid  = (st.cnt != '0);
  assign q.pop_data   = st.mem[st.rd];

  // Next state: write, read, and count update
  always_comb
  begin
    logic do_push;
    logic do_pop;
    do_push = q.push_valid && q.push_ready;
    do_pop  = q.pop_valid && q.pop_ready;
    next_st = st;
    if (do_push)
    begin
      next_st.mem[st.wr] = q.push_data;
      next_st.wr         = st.wr + 1'b1;
    end
    if (do_pop)
    begin
      next_st.rd = st.rd + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// [src/irpe_top.sv]
// Infrared pulse encoder/decoder between a host UART and an optical transceiver

// How it works
// - While the filtered reset pin reads low, all encode and decode logic stays idle.
// - Once the filtered reset pin reads high, encoding and decoding start.
// - The reset pin is filtered so short glitches never reset the device.
// - In reset the host serial output is high and the pulse output low.
// - A host start bit raises the pulse output 7 to 8 bit clocks later.
// - A received pulse drives the host output low 3 to 4 bit clocks later.
// - Bit timing is counted on bit clock edges; limiter, pulse width and reset filter count SYS_CLK cycles.
// - A bit time is 16 bit clocks; a frame holds ten bit times.
// - A zero bit is low 7, high 3, then low 6 bit clocks.
// - A one bit keeps the pulse output low for the whole bit time.
// - A limiter ends any high pulse after 4.00 us whatever the baud rate.
// - A low pulse of at least 1.6 us decodes as zero; none means one.
// - Each decoded zero stays on the host output for a full bit time.
// - While a pulse is being received, transmission is suppressed.
// - Bit timing starts at the detected start edge, bits 16 clocks apart.
// - Holding the reset pin low stops the internal state machine.
module irpe_top
  import irpe_pkg::*;
#(
  parameter int FIFO_DEPTH = irpe_pkg::FIFO_DEPTH
)
(
  // System clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  // Device reset and bit clock pins
  input  wire logic DEV_RESET_N,
  input  wire logic BIT_CLOCK_X16,
  // Host UART side
  input  wire logic HOST_TX_IN,
  output logic      HOST_RX_OUT,
  // Optical transceiver side
  input  wire logic IR_PULSE_IN,
  output logic      IR_PULSE_OUT
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                bclk_m;
    logic                bclk_s;
    logic                bclk_d;
    logic                tick;
    logic                rst_m;
    logic                rst_s;
    logic                rst_ok;
    logic [FILT_W-1:0]   filt_cnt;
    logic                host_m;
    logic                host_s;
    logic                ir_m;
    logic                ir_s;
    logic                ir_d;
    irpe_enc_t           enc_state;
    logic [TICK_W-1:0]   enc_cnt;
    logic [SLOT_W-1:0]   enc_slot;
    logic                push_pend;
    logic                push_bit;
    logic                shp_active;
    logic [TICK_W-1:0]   hi_ticks;
    logic [LIMIT_W-1:0]  lim;
    logic [LIMIT_W:0]    hi_len;
    irpe_dec_t           dec_state;
    logic [TICK_W-1:0]   dec_cnt;
    logic [PULSE_W-1:0]  low_cyc;
    logic                qual;
    logic                out_low;
    logic [TICK_W-1:0]   out_cnt;
    logic                host_rx;
  } irpe_st_t;

  // Clears the core state the device reset pin governs; the FIFO has its own reset; synchronisers keep running
  function automatic irpe_st_t core_reset(input irpe_st_t s);
    irpe_st_t r;
    r            = s;
    r.enc_state  = ENC_IDLE;
    r.enc_cnt    = '0;
    r.enc_slot   = '0;
    r.push_pend  = 1'b0;
    r.push_bit   = 1'b0;
    r.shp_active = IR_IDLE;
    r.hi_ticks   = '0;
    r.lim        = '0;
    r.hi_len     = '0;
    r.dec_state  = DEC_IDLE;
    r.dec_cnt    = '0;
    r.low_cyc    = '0;
    r.qual       = 1'b0;
    r.out_low    = 1'b0;
    r.out_cnt    = '0;
    r.host_rx    = HOST_IDLE;
    return r;
  endfunction

  // Power-on value; idle line levels avoid a false start edge at release
  function automatic irpe_st_t st_init();
    irpe_st_t r;
    r        = '0;
    r.host_m = 1'b1;
    r.host_s = 1'b1;
    r.ir_m   = 1'b1;
    r.ir_s   = 1'b1;
    r.ir_d   = 1'b1;
    return core_reset(r);
  endfunction

  localparam irpe_st_t ST_INIT = st_init();

  irpe_st_t st;
  irpe_st_t next_st;
  logic     fifo_rst;

  irpe_fifo_if #(.WIDTH(FIFO_WIDTH)) fq ();

  // ****************************************************************
  // Bit FIFO between sampler and pulse shaper
  // ****************************************************************
  // Flushed with the device so no stale bit leaks out after reset
  assign fifo_rst      = RESET || !st.rst_ok;
  assign fq.push_valid = st.push_pend;
  assign fq.push_data  = st.push_bit;
  assign fq.pop_ready  = !st.shp_active;

  irpe_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk (SYS_CLK),
    .rst (fifo_rst),
    .q   (fq)
  );

  // Outputs come straight from flip-flops
  assign HOST_RX_OUT  = st.host_rx;
  assign IR_PULSE_OUT = st.shp_active;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic ir_busy;
    ir_busy = !st.ir_s;
    next_st = st;
    // Pin synchronisers; first stages feed only second stages
    next_st.bclk_m = BIT_CLOCK_X16;
    next_st.bclk_s = st.bclk_m;
    next_st.bclk_d = st.bclk_s;
    next_st.tick   = st.bclk_s && !st.bclk_d;
    next_st.rst_m  = DEV_RESET_N;
    next_st.rst_s  = st.rst_m;
    next_st.host_m = HOST_TX_IN;
    next_st.host_s = st.host_m;
    next_st.ir_m   = IR_PULSE_IN;
    next_st.ir_s   = st.ir_m;
    next_st.ir_d   = st.ir_s;

    // Reset pin filter: level accepted only after it stays put long enough
    if (st.rst_s != st.rst_ok)
    begin
      if (st.filt_cnt == FILT_W'(RST_FILT_CYC - 1))
      begin
        next_st.rst_ok   = st.rst_s;
        next_st.filt_cnt = '0;
      end
      else
      begin
        next_st.filt_cnt = st.filt_cnt + 1'b1;
      end
    end
    else
    begin
      next_st.filt_cnt = '0;
    end

    // Sampler: frame timed from the detected start edge
    if (st.push_pend && fq.push_ready)
    begin
      next_st.push_pend = 1'b0;
    end
    case (st.enc_state)
      ENC_IDLE:
      begin
        if (st.tick && !st.host_s)
        begin
          next_st.enc_state = ENC_FRAME;
          next_st.enc_cnt   = '0;
          next_st.enc_slot  = '0;
        end
      end
      ENC_FRAME:
      begin
        if (st.tick)
        begin
          next_st.enc_cnt = st.enc_cnt + 1'b1;
          // Mid-bit sample also places the pulse 7 to 8 clocks after the edge
          if (next_st.enc_cnt == ENC_SAMPLE_TICK)
          begin
            next_st.push_pend = 1'b1;
            next_st.push_bit  = st.host_s;
          end
          if (st.enc_cnt == SLOT_LAST_TICK)
          begin
            if (st.enc_slot == FRAME_LAST_SLOT)
            begin
              next_st.enc_state = ENC_IDLE;
            end
            else
            begin
              next_st.enc_slot = st.enc_slot + 1'b1;
            end
          end
        end
      end
      default:
      begin
        next_st.enc_state = ENC_IDLE;
      end
    endcase

    // Pulse shaper: zero gives a three-clock pulse, cut by limiter or reception
    if (st.shp_active)
    begin
      next_st.lim    = st.lim + 1'b1;
      next_st.hi_len = st.hi_len + 1'b1;
      if (st.tick)
      begin
        next_st.hi_ticks = st.hi_ticks + 1'b1;
      end
      if (ir_busy)
      begin
        next_st.shp_active = 1'b0;
      end
      else if (st.lim == LIMIT_W'(LIMIT_CYC - 1))
      begin
        next_st.shp_active = 1'b0;
      end
      else if (st.tick && st.hi_ticks == ENC_HIGH_TICKS - 4'h1)
      begin
        next_st.shp_active = 1'b0;
      end
    end
    else
    begin
      next_st.hi_len = '0;
      // A one bit is popped and leaves the output low
      if (fq.pop_valid && !fq.pop_data && !ir_busy)
      begin
        next_st.shp_active = 1'b1;
        next_st.hi_ticks   = '0;
        next_st.lim        = '0;
      end
    end

    // Host output timer: one bit time per decoded zero
    if (st.out_low && st.tick)
    begin
      next_st.out_cnt = st.out_cnt + 1'b1;
      if (st.out_cnt == SLOT_LAST_TICK)
      begin
        next_st.out_low = 1'b0;
      end
    end

    // Pulse detector; a later reload keeps back-to-back zeros continuous
    case (st.dec_state)
      DEC_IDLE:
      begin
        if (!st.ir_s && st.ir_d)
        begin
          next_st.dec_state = DEC_WAIT;
          next_st.dec_cnt   = '0;
          next_st.low_cyc   = '0;
          next_st.qual      = 1'b0;
        end
      end
      DEC_WAIT:
      begin
        if (!st.ir_s && !st.qual)
        begin
          next_st.low_cyc = st.low_cyc + 1'b1;
          if (st.low_cyc == PULSE_MIN_CYC[PULSE_W-1:0] - 1'b1)
          begin
            next_st.qual = 1'b1;
          end
        end
        if (st.ir_s && !st.qual)
        begin
          next_st.dec_state = DEC_IDLE;
        end
        else if (st.tick)
        begin
          next_st.dec_cnt = st.dec_cnt + 1'b1;
          if (st.dec_cnt == DEC_DELAY_TICKS - 4'h1)
          begin
            next_st.dec_state = DEC_IDLE;
            if (st.qual)
            begin
              next_st.out_low = 1'b1;
              next_st.out_cnt = '0;
            end
          end
        end
      end
      default:
      begin
        next_st.dec_state = DEC_IDLE;
      end
    endcase
    next_st.host_rx = !next_st.out_low;

    // Device reset pin freezes the state machines at their idle levels
    if (!st.rst_ok)
    begin
      next_st = core_reset(next_st);
    end
  end

  // State register; release starts operation once the filter agrees
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      st <= ST_INIT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_pulse_rise;
    $rose(IR_PULSE_OUT);
  endsequence

  sequence s_glitch_seen;
    st.dec_state == DEC_WAIT && st.ir_s && !st.qual;
  endsequence

  sequence s_one_popped;
    fq.pop_valid && fq.pop_ready && fq.pop_data;
  endsequence

  a_reset_levels: assert property (
    !st.rst_ok |=> (HOST_RX_OUT && !IR_PULSE_OUT))
    else $error("outputs not at reset levels");

  a_filter_time: assert property (
    $changed(st.rst_ok) |-> $past(st.filt_cnt) == FILT_W'(RST_FILT_CYC - 1))
    else $error("reset filter accepted level too early");

  a_pulse_start: assert property (
    s_pulse_rise |-> st.enc_state == ENC_FRAME && st.enc_cnt == ENC_SAMPLE_TICK)
    else $error("pulse not at sample tick");

  a_one_silent: assert property (
    s_one_popped |=> !IR_PULSE_OUT)
    else $error("one bit raised the pulse output");

  a_high_limit: assert property (
    st.hi_len <= (LIMIT_W + 1)'(LIMIT_CYC))
    else $error("pulse longer than limiter");

  a_half_duplex: assert property (
    !st.ir_s |=> !IR_PULSE_OUT)
    else $error("transmit during reception");

  a_dec_delay: assert property (
    $fell(HOST_RX_OUT) |-> $past(st.tick) && $past(st.dec_cnt) == DEC_DELAY_TICKS - 4'h1)
    else $error("decoded low at wrong tick");

  a_dec_hold: assert property (
    $rose(HOST_RX_OUT) && $past(st.rst_ok) |-> $past(st.out_cnt) == SLOT_LAST_TICK)
    else $error("decoded bit not held a bit time");

  a_glitch_drop: assert property (
    s_glitch_seen |=> st.dec_state == DEC_IDLE && !st.out_low || $past(st.out_low))
    else $error("short pulse not dropped");

  a_tick_edge: assert property (
    st.tick |-> $past(st.bclk_s) && !$past(st.bclk_d))
    else $error("tick without bit clock edge");

endmodule

// [verif/irpe_partner.sv]
// Host UART, optical transceiver and bit clock source facing the device
module irpe_partner
(
  // System clock
  input  wire logic clk,
  // Device pins
  output logic      bck,
  output logic      tx,
  output logic      ir,
  input  wire logic rx,
  input  wire logic irout
);
  timeunit 1ns;
  timeprecision 1ns;

  int   half = 6;
  logic run  = 1'h0;
  logic hold = 1'h0;
  logic ir_d = 1'h1;
  int   hc   = 0;
  int   cyc, npul, w, wmin, wmax, rise1, fall1, nlow;

  // Idle levels at time zero
  initial
  begin
    bck = 1'h0;
    tx  = 1'h1;
    clear();
  end

  // Line idles high; hold stands for one endless incoming pulse
  assign ir = ir_d & ~hold;

  // ****************************************
  // Bit clock source
  // ****************************************
  // Stopped while run is low, so the bench changes the rate only between characters
  always @(negedge clk)
  begin
    if (!run)
      hc = 0;
    else if (hc >= half - 1)
    begin
      hc  = 0;
      bck = ~bck;
    end
    else
      hc = hc + 1;
  end

  // Pulse and host line statistics since the last clear
  always @(posedge clk)
  begin
    cyc++;
    if (rx === 1'h0 && nlow == 0)
      fall1 = cyc;
    if (rx === 1'h0)
      nlow++;
    if (irout === 1'h1)
    begin
      if (w == 0 && npul == 0)
        rise1 = cyc;
      w++;
    end
    else if (w > 0)
    begin
      npul++;
      wmin = (w < wmin) ? w : wmin;
      wmax = (w > wmax) ? w : wmax;
      w    = 0;
    end
  end

  task automatic clear();
    cyc   = 0;
    npul  = 0;
    w     = 0;
    wmin  = 999;
    wmax  = 0;
    rise1 = 0;
    fall1 = 0;
    nlow  = 0;
  endtask

  // Host UART: start bit, eight data bits LSB first, stop bit
  task automatic host_send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    @(posedge bck);
    clear();
    for (int i = 0; i < 10; i++)
    begin
      tx = f[i];
      repeat (16) @(posedge bck);
    end
  endtask

  // Transceiver: a low pulse of lo cycles at the start of each zero slot
  task automatic ir_send(input logic [7:0] d, input int lo);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    @(posedge bck);
    clear();
    for (int i = 0; i < 10; i++)
    begin
      ir_d = f[i];
      fork
        begin
          repeat (lo) @(negedge clk);
          ir_d = 1'h1;
        end
        repeat (16) @(posedge bck);
      join
    end
  endtask

  // Host UART receiver: finds the start bit, then samples each bit mid-way
  task automatic host_recv(input int p, output logic [7:0] d);
    int n;
    n = 0;
    while (rx !== 1'h0 && n < 8 * p)
    begin
      @(negedge clk);
      n++;
    end
    repeat (8 * p) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16 * p) @(negedge clk);
      d[i] = rx;
    end
  endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the infrared pulse encoder/decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic enc; logic [7:0] d; int half; int lo; int cnt; int w;} irpe_row_t;

  logic       clk       = 1'h0;
  logic       rst       = 1'h1;
  logic       dev_rst_n = 1'h1;
  logic [7:0] got;
  wire        bck, tx, ir, rx, irout;
  int         fails     = 0;
  int         cmp_count = 0;
  int         cyc       = 0;
  int         p;

  // Encode rows give pulse count and width, decode rows the zero slot count
  irpe_row_t rows[9] = '{
    '{1'h1, 8'h55, 6, 0, 5, 36},
    '{1'h1, 8'h00, 6, 0, 9, 36},
    '{1'h1, 8'hff, 6, 0, 1, 36},
    '{1'h1, 8'h81, 9, 0, 7, 54},
    '{1'h1, 8'h3c, 20, 0, 5, 80},
    '{1'h0, 8'ha5, 6, 36, 5, 0},
    '{1'h0, 8'h00, 6, 36, 9, 0},
    '{1'h0, 8'hff, 6, 36, 1, 0},
    '{1'h0, 8'h5a, 9, 40, 5, 0}
  };

  always #25 clk = ~clk;

  irpe_top u_dut
  (
    .SYS_CLK       (clk),
    .RESET         (rst),
    .DEV_RESET_N   (dev_rst_n),
    .BIT_CLOCK_X16 (bck),
    .HOST_TX_IN    (tx),
    .HOST_RX_OUT   (rx),
    .IR_PULSE_IN   (ir),
    .IR_PULSE_OUT  (irout)
  );

  irpe_partner u_p
  (
    .clk   (clk),
    .bck   (bck),
    .tx    (tx),
    .ir    (ir),
    .rx    (rx),
    .irout (irout)
  );

  // Cuts a hang short well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic check_rng(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  task automatic complete_run();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (12) @(negedge clk);
    check({31'h0, rx}, 32'h1);
    check({31'h0, irout}, 32'h0);
    rst = 1'h0;
    repeat (30) @(negedge clk);
    foreach (rows[i])
    begin
      // Rate changes only while the bit clock stands still
      u_p.run  = 1'h0;
      repeat (2) @(negedge clk);
      u_p.half = rows[i].half;
      u_p.run  = 1'h1;
      repeat (4) @(posedge bck);
      p = 2 * rows[i].half;
      if (rows[i].enc)
      begin
        u_p.host_send(rows[i].d);
        check(u_p.npul, rows[i].cnt);
        check_rng(u_p.wmin, rows[i].w - 2, rows[i].w + 2);
        check_rng(u_p.wmax, rows[i].w - 2, rows[i].w + 2);
        check_rng(u_p.rise1, 7 * p, 8 * p + 8);
      end
      else
      begin
        fork
          u_p.ir_send(rows[i].d, rows[i].lo);
          u_p.host_recv(p, got);
        join
        check(got, rows[i].d);
        check_rng(u_p.fall1, 3 * p, 4 * p + 8);
        check_rng(u_p.nlow, 16 * p * rows[i].cnt - 8, 16 * p * rows[i].cnt + 8);
      end
    end
    // Pulses shorter than the minimum are dropped
    u_p.ir_send(8'h00, 20);
    check(u_p.nlow, 0);
    // A long incoming pulse blocks transmission
    u_p.hold = 1'h1;
    u_p.host_send(8'h00);
    u_p.hold = 1'h0;
    check(u_p.npul, 0);
    repeat (40) @(negedge clk);
    // A short reset glitch in mid-frame changes nothing
    fork
      u_p.host_send(8'h00);
      begin
        repeat (300) @(negedge clk);
        dev_rst_n = 1'h0;
        repeat (8) @(negedge clk);
        dev_rst_n = 1'h1;
      end
    join
    check(u_p.npul, 9);
    // Held device reset silences both directions
    dev_rst_n = 1'h0;
    repeat (40) @(negedge clk);
    fork
      u_p.host_send(8'h00);
      u_p.ir_send(8'h00, 40);
    join
    check(u_p.npul, 0);
    check(u_p.nlow, 0);
    dev_rst_n = 1'h1;
    repeat (30) @(negedge clk);
    u_p.host_send(8'hff);
    check(u_p.npul, 1);
    complete_run();
  end
endmodule
